// ---- rtl/low_voltage_detector_control.sv ----
// supply detector control: reset/interrupt generation from a low-voltage comparator
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module low_voltage_detector_control (
   input wire logic clk,
   input wire logic rst,
   input wire logic default_start_option,
   input wire logic comparator_below,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic [3:0] threshold_select_bits,
   output logic comparator_on,
   output logic internal_reset,
   output logic supply_crossing_interrupt
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   lvd_pkg::ctrl_type ctrl_reg, ctrl_next;
   logic [3:0] thresh_reg, thresh_next;
   logic sync1_reg, sync2_reg, below_reg;
   logic below_next;
   logic req_reg, req_next, mask_reg, mask_next;
   logic rsrc_reg, rsrc_next, lvd_rst_reg, lvd_rst_next;
   logic irq_next;
   logic [7:0] rdata_next;
   logic started_reg;
   logic active;
   logic crossing;

   assign active = ctrl_reg.enable | (default_start_option & ~started_reg);
   assign crossing = ctrl_reg.enable & ~ctrl_reg.mode & (sync2_reg != below_reg);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      ctrl_next = ctrl_reg;
      thresh_next = thresh_reg;
      below_next = active ? sync2_reg : 1'b0;
      req_next = req_reg;
      mask_next = mask_reg;
      rsrc_next = rsrc_reg;
      irq_next = 1'b0;
      rdata_next = 8'h00;
      // reset only on a level, so entering reset mode while above makes none
      lvd_rst_next = active & (ctrl_reg.mode | ~started_reg) & sync2_reg;
      if (wr) begin
         case (addr)
            lvd_pkg::ctrl_addr: begin
               ctrl_next.enable = wdata[lvd_pkg::enable_bit];
               ctrl_next.mode = wdata[lvd_pkg::mode_bit];
               if (ctrl_reg.enable & ~wdata[lvd_pkg::enable_bit] & ~ctrl_reg.mode & sync2_reg) begin
                  irq_next = 1'b1;
               end
            end
            lvd_pkg::thresh_addr: thresh_next = wdata[3:0];
            lvd_pkg::int_addr: begin
               req_next = wdata[lvd_pkg::req_bit];
               mask_next = wdata[lvd_pkg::mask_bit];
            end
            lvd_pkg::rsrc_addr: rsrc_next = wdata[lvd_pkg::rsrc_bit];
            default: ;
         endcase
      end
      if (crossing) begin
         irq_next = 1'b1;
      end
      if (irq_next) begin
         req_next = 1'b1; // set wins over a same-cycle clear
      end
      if (lvd_rst_reg) begin
         rsrc_next = 1'b1;
      end
      if (rd) begin
         case (addr)
            lvd_pkg::ctrl_addr: rdata_next = {ctrl_reg.enable, 5'h00, ctrl_reg.mode, below_reg};
            lvd_pkg::thresh_addr: rdata_next = {4'h0, thresh_reg};
            lvd_pkg::int_addr: rdata_next = {6'h00, mask_reg, req_reg};
            lvd_pkg::rsrc_addr: rdata_next = {7'h00, rsrc_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      sync1_reg <= comparator_below;
      sync2_reg <= sync1_reg;
      if (rst) begin
         // a reset raised by this block after the power-up hold keeps its own settings
         if (!lvd_rst_reg || !started_reg) begin
            ctrl_reg <= '0;
            thresh_reg <= lvd_pkg::thresh_reset;
         end
         mask_reg <= 1'b1;
         req_reg <= 1'b0;
         rsrc_reg <= rsrc_next;
         below_reg <= 1'b0;
         lvd_rst_reg <= lvd_rst_next;
         rdata <= 8'h00;
         started_reg <= started_reg & lvd_rst_reg;
      end else begin
         ctrl_reg <= ctrl_next;
         thresh_reg <= thresh_next;
         mask_reg <= mask_next;
         req_reg <= req_next;
         rsrc_reg <= rsrc_next;
         below_reg <= below_next;
         lvd_rst_reg <= lvd_rst_next;
         rdata <= rdata_next;
         started_reg <= started_reg | ~lvd_rst_next;
      end
   end

   always_ff @(posedge clk) begin
      threshold_select_bits <= (default_start_option & ~started_reg) ?
         lvd_pkg::lowest_threshold : thresh_reg;
      comparator_on <= active;
      internal_reset <= lvd_rst_next;
      // no pulse while reset holds, the mask is forced on then anyway
      supply_crossing_interrupt <= ~rst & irq_next & ~mask_next;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // every check reads the comparator after both sync stages, never the raw pin
   sequence s_mode_reset_on;
      ctrl_reg.mode && ctrl_reg.enable && started_reg && sync2_reg;
   endsequence

   sequence s_masked_quiet;
      mask_reg && !(wr && addr == lvd_pkg::int_addr);
   endsequence

   sequence s_flag_kept;
      rsrc_reg && !(wr && addr == lvd_pkg::rsrc_addr);
   endsequence

   sequence s_default_hold;
      default_start_option && !started_reg;
   endsequence

   sequence s_own_reset;
      rst && lvd_rst_reg && started_reg;
   endsequence

   // ----------------------------------------
   // checks: reset generation
   // ----------------------------------------
   a_reset_follows_low: assert property (@(posedge clk) disable iff (rst)
      s_mode_reset_on |=> lvd_rst_reg) else $error("no reset while low");
   a_reset_pin_low: assert property (@(posedge clk) disable iff (rst)
      s_mode_reset_on |=> internal_reset) else $error("reset pin idle while low");
   // entering reset mode with the supply high must stay quiet
   a_no_reset_high: assert property (@(posedge clk) disable iff (rst)
      !sync2_reg |=> !lvd_rst_reg) else $error("reset while high");
   // interrupt mode never pulls reset once the power-up hold is over
   a_int_mode_quiet: assert property (@(posedge clk) disable iff (rst)
      (!ctrl_reg.mode && started_reg) |=> !internal_reset)
      else $error("reset in interrupt mode");
   a_default_start: assert property (@(posedge clk) disable iff (rst)
      (default_start_option && !started_reg && sync2_reg) |=> lvd_rst_reg)
      else $error("no power-up reset");
   a_default_thresh: assert property (@(posedge clk)
      s_default_hold |=> threshold_select_bits == lvd_pkg::lowest_threshold)
      else $error("power-up threshold wrong");

   // ----------------------------------------
   // checks: reset side effects
   // ----------------------------------------
   // a reset raised here must not wipe the settings that raised it
   a_own_reset_keeps: assert property (@(posedge clk)
      s_own_reset |=> $stable(ctrl_reg) && $stable(thresh_reg))
      else $error("settings lost");
   a_other_reset_clears: assert property (@(posedge clk)
      (rst && !lvd_rst_reg) |=> !ctrl_reg.enable && !ctrl_reg.mode)
      else $error("ctrl kept");
   a_mask_on_reset: assert property (@(posedge clk)
      rst |=> mask_reg) else $error("mask not set");
   a_source_recorded: assert property (@(posedge clk)
      lvd_rst_reg |=> rsrc_reg) else $error("source not recorded");
   // only a software write may drop the source flag
   a_source_kept: assert property (@(posedge clk) disable iff (rst)
      s_flag_kept |=> rsrc_reg) else $error("source flag dropped");

   // ----------------------------------------
   // checks: flag, read data and interrupt
   // ----------------------------------------
   a_flag_tracks: assert property (@(posedge clk) disable iff (rst)
      active |=> below_reg == $past(sync2_reg)) else $error("flag wrong");
   a_flag_idle: assert property (@(posedge clk) disable iff (rst)
      !active |=> !below_reg) else $error("flag set while idle");
   a_rdata_idle: assert property (@(posedge clk)
      !rd |=> rdata == 8'h00) else $error("read data without read");
   a_crossing_sets_req: assert property (@(posedge clk) disable iff (rst)
      crossing |=> req_reg) else $error("crossing lost");
   // the pin pulse and the request flag come from one edge, so they agree
   a_pulse_sets_req: assert property (@(posedge clk) disable iff (rst)
      supply_crossing_interrupt |-> req_reg) else $error("pulse without request");
   // a masked request still reaches the flag for polling, but not the pin
   a_masked_no_pulse: assert property (@(posedge clk) disable iff (rst)
      s_masked_quiet |=> !supply_crossing_interrupt) else $error("pulse while masked");
   a_disable_irq: assert property (@(posedge clk) disable iff (rst)
      (wr && addr == lvd_pkg::ctrl_addr && ctrl_reg.enable && !ctrl_reg.mode
       && !wdata[lvd_pkg::enable_bit] && sync2_reg) |=> req_reg)
      else $error("disable irq lost");
endmodule : low_voltage_detector_control

// ---- rtl/lvd_pkg.sv ----
// package: register map, field positions and reset values of the supply detector control
package lvd_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [1:0] ctrl_addr = 2'h0;
   localparam logic [1:0] thresh_addr = 2'h1;
   localparam logic [1:0] int_addr = 2'h2;
   localparam logic [1:0] rsrc_addr = 2'h3;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int enable_bit = 7;
   localparam int mode_bit = 1;
   localparam int flag_bit = 0;
   localparam int rsrc_bit = 0;
   localparam int req_bit = 0;
   localparam int mask_bit = 1;
   // ----------------------------------------
   // reset values and timing
   // ----------------------------------------
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [3:0] thresh_reset = 4'h0;
   localparam logic [3:0] lowest_threshold = 4'hA;
   localparam int stab_time_ns = 10000;
   localparam int clk_period_ns = 5;
   localparam int stab_cycles = (stab_time_ns + clk_period_ns - 1) / clk_period_ns;

   typedef struct packed {
      logic enable;
      logic mode;
   } ctrl_type;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;
endpackage : lvd_pkg

// ---- dv/low_voltage_detector_control_bench.sv ----
// testbench: register port and comparator stimulus for the supply detector control
`timescale 1ns/100ps
module low_voltage_detector_control_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic default_start_option = 1'b0;
   logic comparator_below = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [3:0] threshold_select_bits;
   logic comparator_on;
   logic internal_reset;
   logic supply_crossing_interrupt;
   int failures = 0;
   int tests_run = 0;
   always #2.5 clk = ~clk;
   low_voltage_detector_control i_dut (.clk(clk), .rst(rst),
      .default_start_option(default_start_option), .comparator_below(comparator_below),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .threshold_select_bits(threshold_select_bits), .comparator_on(comparator_on),
      .internal_reset(internal_reset), .supply_crossing_interrupt(supply_crossing_interrupt));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_chk
   task automatic pulse_rst(input int n);
      @(posedge clk) rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse_rst
   // a crossing takes two sync stages and a register, so six edges is ample
   task automatic irq_chk(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (6) begin
         @(posedge clk);
         #1 if (supply_crossing_interrupt === 1'b1) seen = 1'b1;
      end
      chk({7'h0, seen}, {7'h0, exp});
   endtask : irq_chk
   task automatic set_cmp(input logic v);
      @(posedge clk) comparator_below <= v;
   endtask : set_cmp
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic reset_values;
      rd_chk(lvd_pkg::ctrl_addr, 8'h00);
      rd_chk(lvd_pkg::thresh_addr, 8'h00);
      rd_chk(lvd_pkg::int_addr, 8'h02);
      rd_chk(lvd_pkg::rsrc_addr, 8'h00);
   endtask : reset_values
   task automatic int_mode;
      wr_reg(lvd_pkg::thresh_addr, 8'h03);
      wr_reg(lvd_pkg::ctrl_addr, 8'h80);
      wr_reg(lvd_pkg::int_addr, 8'h00);
      #1 chk({4'h0, threshold_select_bits}, 8'h03);
      chk({7'h0, comparator_on}, 8'h01);
      set_cmp(1'b1);
      irq_chk(1'b1);
      rd_chk(lvd_pkg::ctrl_addr, 8'h81);
      rd_chk(lvd_pkg::int_addr, 8'h01);
      set_cmp(1'b0);
      irq_chk(1'b1);
      chk({7'h0, internal_reset}, 8'h00);
      wr_reg(lvd_pkg::int_addr, 8'h02);
      set_cmp(1'b1);
      irq_chk(1'b0);
      wr_reg(lvd_pkg::int_addr, 8'h00);
      wr_reg(lvd_pkg::ctrl_addr, 8'h00);
      #1 chk({7'h0, supply_crossing_interrupt}, 8'h01);
      set_cmp(1'b0);
      repeat (4) @(posedge clk);
   endtask : int_mode
   task automatic reset_mode;
      wr_reg(lvd_pkg::int_addr, 8'h02);
      wr_reg(lvd_pkg::thresh_addr, 8'h05);
      wr_reg(lvd_pkg::ctrl_addr, 8'h80);
      wr_reg(lvd_pkg::ctrl_addr, 8'h82);
      repeat (5) @(posedge clk);
      #1 chk({7'h0, internal_reset}, 8'h00);
      set_cmp(1'b1);
      repeat (4) @(posedge clk);
      #1 chk({7'h0, internal_reset}, 8'h01);
      // one edge only: the detector reset must still be visible when rst is taken
      pulse_rst(1);
      rd_chk(lvd_pkg::ctrl_addr, 8'h83);
      rd_chk(lvd_pkg::thresh_addr, 8'h05);
      rd_chk(lvd_pkg::rsrc_addr, 8'h01);
      rd_chk(lvd_pkg::int_addr, 8'h02);
      set_cmp(1'b0);
      repeat (4) @(posedge clk);
      #1 chk({7'h0, internal_reset}, 8'h00);
      wr_reg(lvd_pkg::ctrl_addr, 8'h80);
      rd_chk(lvd_pkg::ctrl_addr, 8'h80);
      wr_reg(lvd_pkg::rsrc_addr, 8'h00);
      pulse_rst(5);
      rd_chk(lvd_pkg::ctrl_addr, 8'h00);
      rd_chk(lvd_pkg::rsrc_addr, 8'h00);
   endtask : reset_mode
   task automatic default_start;
      @(posedge clk) begin default_start_option <= 1'b1; comparator_below <= 1'b1; end
      pulse_rst(5);
      #1 chk({7'h0, internal_reset}, 8'h01);
      chk({4'h0, threshold_select_bits}, {4'h0, lvd_pkg::lowest_threshold});
      set_cmp(1'b0);
      repeat (4) @(posedge clk);
      #1 chk({7'h0, internal_reset}, 8'h00);
   endtask : default_start
   // ----------------------------------------
   // sequence and verdict
   // ----------------------------------------
   task automatic results;
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reset_values();
      int_mode();
      reset_mode();
      default_start();
      results();
   end
   initial begin
      #20000;
      failures++;
      results();
   end
endmodule : low_voltage_detector_control_bench
